// [inc/gpio_port_map.svh]
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

// register byte offsets, one 32-bit word each
`define OFF_PIN_LEVEL     6'h00
`define OFF_OUTPUT_LATCH  6'h04
`define OFF_DIRECTION     6'h08
`define OFF_ANALOG_SELECT 6'h0c
`define OFF_WEAK_PULLUP   6'h10
`define OFF_SOURCE_CC     6'h14
`define OFF_SINK_CC       6'h18
`define OFF_IN_THRESHOLD  6'h1c
`define OFF_SLEW_LIMIT    6'h20
`define OFF_OPEN_DRAIN    6'h24
`define OFF_CC_CONFIG     6'h28
`define OFF_PIN_ROUTE     6'h2c

// current_drive_config_reg fields
`define CC_GLOBAL_BIT     7
`define CC_LEVEL_LSB      0
`define CC_LEVEL_MSB      1

// reset values; the per-bit ones are replicated across the port width, the cc level is a 2-bit field
`define RST_LATCH_BIT     1'b0
`define RST_DIR_BIT       1'b1
`define RST_ANSEL_BIT     1'b1
`define RST_OTHER_BIT     1'b0
`define RST_CC_LEVEL      2'h0

`define DATA_LANE         0

`endif

// [inc/gpio_port_pkg.sv]
package gpio_port_pkg;

  // everything that decides one pad's output path
  typedef struct packed {
    logic latch;
    logic direction;
    logic open_drain;
    logic periph_route;
    logic periph_val;
    logic analog_out;
  } pin_drive_t;

  // what one pad is given
  typedef struct packed {
    logic value;
    logic oe_n;
  } pin_pad_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // pin_sync

// [hw/pin_slice.sv]
`timescale 1ns/1ps

module pin_slice
  import gpio_port_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire pin_drive_t drive,
  output pin_pad_t        pad
);

  logic     value_d;
  pin_pad_t pad_d;

  always_comb begin
    // latch drives unless a routed peripheral owns the pin
    value_d = drive.periph_route ? drive.periph_val : drive.latch;
    pad_d.value = value_d;
    pad_d.oe_n  = 1'b1;
    if (drive.analog_out) begin
      pad_d.oe_n = 1'b1;
    end else if (!drive.direction) begin
      // analog input mode does not enter here: output still allowed
      pad_d.oe_n = drive.open_drain & value_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad.value <= 1'b0;
      pad.oe_n  <= 1'b1;
    end else begin
      pad <= pad_d;
    end
  end

endmodule // pin_slice

// [hw/gpio_port_pin_control.sv]
// Function
// - a write to output latch or pin level register updates the latch
// - latch register reads stored latch; pin level register reads sampled pins
// - analog select disables the digital input buffer of that pin
// - a routed peripheral replaces the latch while it requests the pin; pin stays readable
// - after reset every pin output comes from its latch
// - enabled analog output forces the digital driver to high impedance
// - analog select never blocks digital output
// - analog input functions active only when analog select is set
// - one config register: global current-drive enable and level select
// - per-pin source and sink current-control enables
// - current control applies whichever source drives the pin
// - each port has the full set of eleven pin registers
// - direction 1 disables the driver; 0 drives the output value
// - digital reads of analog-selected pins return zero
// - open-drain select makes the pin sink-only, else push-pull
`timescale 1ns/1ps
`include "gpio_port_map.svh"

module gpio_port_pin_control
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // avalon-mm slave
  input  wire logic [5:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [31:0]      writedata,
  input  wire logic [3:0]       byteenable,
  output logic      [31:0]      readdata,
  output logic                  waitrequest,
  // pads
  input  wire logic [WIDTH-1:0] pad_in,
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe_n,
  output logic      [WIDTH-1:0] pullup_en,
  output logic      [WIDTH-1:0] slew_limit_en,
  output logic      [WIDTH-1:0] threshold_sel,
  output logic      [WIDTH-1:0] source_cc_en,
  output logic      [WIDTH-1:0] sink_cc_en,
  output logic                  cc_global_en,
  output logic      [1:0]       cc_level,
  // on-chip peripherals
  input  wire logic [WIDTH-1:0] periph_req,
  input  wire logic [WIDTH-1:0] periph_out,
  input  wire logic [WIDTH-1:0] analog_out_en,
  output logic      [WIDTH-1:0] periph_in,
  output logic      [WIDTH-1:0] analog_in_en
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic [WIDTH-1:0] output_latch_q;
  logic [WIDTH-1:0] direction_q;
  logic [WIDTH-1:0] analog_select_q;
  logic [WIDTH-1:0] weak_pullup_q;
  logic [WIDTH-1:0] source_cc_q;
  logic [WIDTH-1:0] sink_cc_q;
  logic [WIDTH-1:0] threshold_q;
  logic [WIDTH-1:0] slew_limit_q;
  logic [WIDTH-1:0] open_drain_q;
  logic [WIDTH-1:0] pin_route_q;
  logic             cc_global_q;
  logic [1:0]       cc_level_q;

  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] pin_level;
  logic [WIDTH-1:0] wr_byte;
  logic [31:0]      readdata_d;
  logic             hit;
  logic             wr_acc;
  bus_state_t       bus_q;

  assign wr_byte   = writedata[WIDTH-1:0];
  assign pin_level = pin_sync & ~analog_select_q;

  ////////////////////////////////////////////////////////////////////////
  // pin sampling

  pin_sync #(
    .WIDTH (WIDTH)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (pad_in),
    .sync_out (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // avalon handshake: one wait cycle, then a single acknowledged cycle

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_q <= BUS_IDLE;
    end else begin
      unique case (bus_q)
        BUS_IDLE: begin
          if (read || write) begin
            bus_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_q <= BUS_IDLE;
        end
        default: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // waitrequest is the idle bit of the state flop, so it leaves a flop directly
  assign waitrequest = bus_q[0];
  // writes land only at the ack edge: a held request writes again every second cycle
  assign wr_acc      = write && (bus_q == BUS_ACK) && byteenable[`DATA_LANE];

  always_comb begin
    hit        = 1'b1;
    readdata_d = '0;
    unique case (address)
      `OFF_PIN_LEVEL:     readdata_d[WIDTH-1:0] = pin_level;
      `OFF_OUTPUT_LATCH:  readdata_d[WIDTH-1:0] = output_latch_q;
      `OFF_DIRECTION:     readdata_d[WIDTH-1:0] = direction_q;
      `OFF_ANALOG_SELECT: readdata_d[WIDTH-1:0] = analog_select_q;
      `OFF_WEAK_PULLUP:   readdata_d[WIDTH-1:0] = weak_pullup_q;
      `OFF_SOURCE_CC:     readdata_d[WIDTH-1:0] = source_cc_q;
      `OFF_SINK_CC:       readdata_d[WIDTH-1:0] = sink_cc_q;
      `OFF_IN_THRESHOLD:  readdata_d[WIDTH-1:0] = threshold_q;
      `OFF_SLEW_LIMIT:    readdata_d[WIDTH-1:0] = slew_limit_q;
      `OFF_OPEN_DRAIN:    readdata_d[WIDTH-1:0] = open_drain_q;
      `OFF_PIN_ROUTE:     readdata_d[WIDTH-1:0] = pin_route_q;
      `OFF_CC_CONFIG: begin
        readdata_d[`CC_GLOBAL_BIT]                = cc_global_q;
        readdata_d[`CC_LEVEL_MSB:`CC_LEVEL_LSB]   = cc_level_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // read data captured in the wait cycle, standing at the ack edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readdata <= '0;
    end else if (read && bus_q == BUS_IDLE) begin
      readdata <= hit ? readdata_d : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes; unmapped writes are dropped

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_latch_q <= {WIDTH{`RST_LATCH_BIT}};
    end else if (wr_acc && (address == `OFF_OUTPUT_LATCH
                           || address == `OFF_PIN_LEVEL)) begin
      // no read-modify-write of the pins: the written byte is the latch
      output_latch_q <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      direction_q     <= {WIDTH{`RST_DIR_BIT}};
      analog_select_q <= {WIDTH{`RST_ANSEL_BIT}};
    end else if (wr_acc) begin
      if (address == `OFF_DIRECTION) begin
        direction_q <= wr_byte;
      end
      if (address == `OFF_ANALOG_SELECT) begin
        analog_select_q <= wr_byte;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      weak_pullup_q <= {WIDTH{`RST_OTHER_BIT}};
      threshold_q   <= {WIDTH{`RST_OTHER_BIT}};
      slew_limit_q  <= {WIDTH{`RST_OTHER_BIT}};
      open_drain_q  <= {WIDTH{`RST_OTHER_BIT}};
      pin_route_q   <= {WIDTH{`RST_OTHER_BIT}};
    end else if (wr_acc) begin
      unique case (address)
        `OFF_WEAK_PULLUP:  weak_pullup_q <= wr_byte;
        `OFF_IN_THRESHOLD: threshold_q   <= wr_byte;
        `OFF_SLEW_LIMIT:   slew_limit_q  <= wr_byte;
        `OFF_OPEN_DRAIN:   open_drain_q  <= wr_byte;
        `OFF_PIN_ROUTE:    pin_route_q   <= wr_byte;
        default: ;
      endcase
    end
  end

  // current-controlled drive configuration
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      source_cc_q <= {WIDTH{`RST_OTHER_BIT}};
      sink_cc_q   <= {WIDTH{`RST_OTHER_BIT}};
      cc_global_q <= `RST_OTHER_BIT;
      cc_level_q  <= `RST_CC_LEVEL;
    end else if (wr_acc) begin
      if (address == `OFF_SOURCE_CC) begin
        source_cc_q <= wr_byte;
      end
      if (address == `OFF_SINK_CC) begin
        sink_cc_q <= wr_byte;
      end
      if (address == `OFF_CC_CONFIG) begin
        cc_global_q <= writedata[`CC_GLOBAL_BIT];
        cc_level_q  <= writedata[`CC_LEVEL_MSB:`CC_LEVEL_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad output paths, one slice per pin

  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    pin_drive_t drv;
    pin_pad_t   pad;
    assign drv.latch        = output_latch_q[i];
    assign drv.direction    = direction_q[i];
    assign drv.open_drain   = open_drain_q[i];
    // route bit alone is not enough: an idle peripheral hands the pin back to the latch
    assign drv.periph_route = pin_route_q[i] & periph_req[i];
    assign drv.periph_val   = periph_out[i];
    assign drv.analog_out   = analog_out_en[i];
    pin_slice u_slice (
      .sys_clk (sys_clk),
      .rst     (rst),
      .drive   (drv),
      .pad     (pad)
    );
    assign pad_out[i]  = pad.value;
    assign pad_oe_n[i] = pad.oe_n;
  end

  ////////////////////////////////////////////////////////////////////////
  // pad controls and on-chip inputs

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pullup_en     <= '0;
      slew_limit_en <= '0;
      threshold_sel <= '0;
      source_cc_en  <= '0;
      sink_cc_en    <= '0;
      cc_global_en  <= 1'b0;
      cc_level      <= `RST_CC_LEVEL;
    end else begin
      pullup_en     <= weak_pullup_q;
      slew_limit_en <= slew_limit_q;
      threshold_sel <= threshold_q;
      // gated by the global enable, so the undefined per-pin-only case is off
      source_cc_en  <= source_cc_q & {WIDTH{cc_global_q}};
      sink_cc_en    <= sink_cc_q & {WIDTH{cc_global_q}};
      cc_global_en  <= cc_global_q;
      cc_level      <= cc_level_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      periph_in    <= '0;
      analog_in_en <= '0;
    end else begin
      periph_in    <= pin_sync & ~analog_select_q;
      analog_in_en <= analog_select_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_latch_write: assert property (
    (write && !waitrequest && byteenable[`DATA_LANE]
     && (address == `OFF_OUTPUT_LATCH || address == `OFF_PIN_LEVEL))
    |=> output_latch_q == $past(writedata[WIDTH-1:0]))
    else $error("latch not updated by write");

  chk_latch_read: assert property (
    (read && !waitrequest && address == `OFF_OUTPUT_LATCH)
    |-> readdata[WIDTH-1:0] == output_latch_q)
    else $error("latch read mismatch");

  chk_pin_read: assert property (
    (read && !waitrequest && address == `OFF_PIN_LEVEL)
    |-> readdata[WIDTH-1:0] == $past(pin_sync & ~analog_select_q))
    else $error("pin level read mismatch");

  chk_input_gate: assert property (
    $stable(analog_select_q) |-> (periph_in & analog_select_q) == '0)
    else $error("analog pin seen by digital input");

  chk_analog_hiz: assert property (
    (~pad_oe_n & $past(analog_out_en)) == '0)
    else $error("driver on under analog output");

  chk_dir_drive: assert property (
    ((pad_oe_n & $past(~direction_q & ~analog_out_en & ~open_drain_q)) == '0)
    && ((~pad_oe_n & $past(direction_q)) == '0))
    else $error("driver enable disagrees with direction");

  chk_od_sink: assert property (
    (~pad_oe_n & pad_out & $past(open_drain_q)) == '0)
    else $error("open-drain pin sourcing high");

  chk_out_mux: assert property (
    pad_out == $past((pin_route_q & periph_req & periph_out)
                     | (~(pin_route_q & periph_req) & output_latch_q)))
    else $error("pad value source wrong");

  chk_cc_gate: assert property (
    source_cc_en == $past(source_cc_q & {WIDTH{cc_global_q}})
    && sink_cc_en == $past(sink_cc_q & {WIDTH{cc_global_q}}))
    else $error("current-control enable not gated");

  chk_analog_in: assert property (
    $rose(analog_select_q[0]) |=> analog_in_en[0] ##1 analog_in_en[0] || $fell(analog_select_q[0]))
    else $error("analog input not enabled");

  chk_bus_ack: assert property (
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus acknowledge timing");

  chk_unmapped_read: assert property (
    (read && !waitrequest && !hit) |-> readdata == '0)
    else $error("unmapped read not zero");

  // lane 0 off means the port byte is absent: nothing may change
  chk_lane_dropped: assert property (
    (write && !waitrequest && !byteenable[`DATA_LANE])
    |=> $stable(output_latch_q) && $stable(direction_q) && $stable(analog_select_q))
    else $error("write without lane 0 changed a register");

  chk_reset_release: assert property (
    $fell(rst) |-> pad_oe_n == '1 && pad_out == '0 && readdata == '0 && waitrequest)
    else $error("outputs not at reset values");

  chk_ctrl_copy: assert property (
    pullup_en == $past(weak_pullup_q) && slew_limit_en == $past(slew_limit_q)
    && threshold_sel == $past(threshold_q))
    else $error("pad control copy stale");

endmodule // gpio_port_pin_control

// [tb/pin_partner.sv]
`timescale 1ns/1ps

module pin_partner #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] pad_out,
  input  wire logic [WIDTH-1:0] pad_oe_n,
  input  wire logic [WIDTH-1:0] pullup_en,
  input  wire logic [WIDTH-1:0] ext_val,
  input  wire logic [WIDTH-1:0] ext_sink,
  output logic      [WIDTH-1:0] pad_in
);
  // a released pin follows the far side; a sink on the far side beats the pull-up
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ~ext_sink & (pullup_en | ext_val));
endmodule // pin_partner

// [tb/test_gpio_port_pin_control.sv]
`timescale 1ns/1ps

module test_gpio_port_pin_control;
  localparam int W     = 8;
  localparam int LIMIT = 12000;
  logic         sys_clk, rst, read, write, waitrequest, cc_global_en;
  logic [5:0]   address;
  logic [31:0]  writedata, readdata, rnd;
  logic [3:0]   byteenable;
  logic [1:0]   cc_level;
  logic [W-1:0] pad_in, pad_out, pad_oe_n, pullup_en, slew_limit_en, threshold_sel;
  logic [W-1:0] source_cc_en, sink_cc_en, periph_req, periph_out, analog_out_en;
  logic [W-1:0] periph_in, analog_in_en, ext_val, ext_sink;
  logic [7:0]   rm [12];
  int           failures, num_checks, cycles;

  gpio_port_pin_control #(.WIDTH(W)) i_dut (.sys_clk, .rst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .pad_in, .pad_out, .pad_oe_n,
    .pullup_en, .slew_limit_en, .threshold_sel, .source_cc_en, .sink_cc_en, .cc_global_en,
    .cc_level, .periph_req, .periph_out, .analog_out_en, .periph_in, .analog_in_en);

  pin_partner #(.WIDTH(W)) i_far (.pad_out, .pad_oe_n, .pullup_en, .ext_val, .ext_sink,
    .pad_in);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [W-1:0] e_val();
    return (rm[11] & periph_req & periph_out) | (~(rm[11] & periph_req) & rm[1]);
  endfunction

  function automatic logic [W-1:0] e_oen();
    return analog_out_en | rm[2] | (rm[9] & e_val());
  endfunction

  function automatic logic [W-1:0] e_lvl();
    return (~e_oen() & e_val()) | (e_oen() & ~ext_sink & (rm[4] | ext_val));
  endfunction

  function automatic logic [31:0] e_reg(input int k);
    if (k > 11) return 32'h0;
    if (k == 0) return {24'h0, e_lvl() & ~rm[3]};
    return {24'h0, rm[k]};
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // an edge always passes before a request, so back-to-back calls never collide
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge sys_clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    write      <= wr;
    read       <= ~wr;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic put(input int k, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, 6'(k * 4), d, be, q);
    if (be[0] && k < 12) begin
      if (k == 0) rm[1] = d[7:0];
      else if (k == 10) rm[10] = d[7:0] & 8'h83;
      else rm[k] = d[7:0];
    end
  endtask

  task automatic check_all;
    logic [31:0] q;
    repeat (5) @(posedge sys_clk);
    check(32'(pad_out), 32'(e_val()));
    check(32'(pad_oe_n), 32'(e_oen()));
    check(32'(periph_in), 32'(e_lvl() & ~rm[3]));
    check(32'(analog_in_en), 32'(rm[3]));
    check(32'({pullup_en, slew_limit_en, threshold_sel}), 32'({rm[4], rm[8], rm[7]}));
    check(32'(source_cc_en), 32'(rm[5] & {W{rm[10][7]}}));
    check(32'(sink_cc_en), 32'(rm[6] & {W{rm[10][7]}}));
    check(32'({cc_global_en, cc_level}), 32'({rm[10][7], rm[10][1:0]}));
    for (int k = 0; k < 13; k++) begin
      bus(1'b0, 6'(k * 4), 32'h0, 4'hf, q);
      check(q, e_reg(k));
    end
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rm[i]) rm[i] = 8'h00;
    rm[2] = 8'hff;
    rm[3] = 8'hff;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge sys_clk);
      cycles++;
      if (cycles >= LIMIT) begin
        failures++;
        finish_test;
      end
    end
  end

  initial begin
    int          k;
    logic [31:0] d;
    rst = 1'b1; read = 1'b0; write = 1'b0; address = 6'h00; writedata = 32'h0;
    byteenable = 4'h0; periph_req = 8'h00; periph_out = 8'h00; analog_out_en = 8'h00;
    ext_val = 8'h00; ext_sink = 8'h00; failures = 0; num_checks = 0; rnd = 32'h65cb;
    do_reset;
    check_all;
    $display("test reset_values done");
    put(2, 32'h00, 4'hf);
    put(1, 32'ha5, 4'hf);
    put(9, 32'h0f, 4'hf);
    check_all;
    periph_req <= 8'hf0;
    periph_out <= 8'h3c;
    put(11, 32'hff, 4'hf);
    check_all;
    analog_out_en <= 8'hff;
    put(0, 32'h5a, 4'hf);
    put(1, 32'h33, 4'he);
    put(12, 32'hff, 4'hf);
    check_all;
    // released pins: pull-ups on the upper nibble, far-side sinks on two lower pins, digital input partly enabled
    ext_sink <= 8'h0c;
    ext_val  <= 8'h81;
    put(4, 32'hf0, 4'hf);
    put(3, 32'h0f, 4'hf);
    check_all;
    $display("test corner_cases done");
    for (int n = 0; n < 60; n++) begin
      rnd = lfsr(rnd);
      k = int'(rnd[7:4]) % 12;
      d = {24'h0, rnd[15:8]};
      if ((k == 5 || k == 6) && !rm[10][7]) d = 32'h0;
      if (k == 10 && (rm[5] | rm[6]) != 8'h00) d[7] = 1'b1;
      put(k, d, {rnd[19:17], rnd[16] | rnd[20]});
      rnd = lfsr(rnd);
      periph_req    <= rnd[7:0];
      periph_out    <= rnd[15:8];
      analog_out_en <= rnd[23:16] & rnd[31:24];
      rnd = lfsr(rnd);
      ext_val  <= rnd[7:0];
      ext_sink <= rnd[15:8] & rnd[23:16];
      if (n % 4 == 3) check_all;
    end
    $display("test random_traffic done");
    do_reset;
    check_all;
    $display("test second_reset done");
    finish_test;
  end
endmodule // test_gpio_port_pin_control
